// ===== hw/cap_sense_cfg.svh
// constants of the capacitive sense controller: addresses, codes, timing
// included by the package and the testbench files; definitions only
`ifndef CAP_SENSE_CFG_SVH
`define CAP_SENSE_CFG_SVH
`define CH_N 24
`define SYS_HZ 250000000
`define BASE_HZ 2000000
`define BASE_DIV (`SYS_HZ / `BASE_HZ)
`define CAL_UNIT_MS 10
`define CAL_UNIT_CYC ((`SYS_HZ / 1000) * `CAL_UNIT_MS)
`define DIV_MIN 11'h020
`define DIV_MAX 11'h400
`define A_CTRL 8'h70
`define A_SEL0 8'h72
`define A_SEL1 8'h73
`define A_SEL2 8'h74
`define A_CINT 8'h76
`define A_CMOD 8'h77
`define A_FILTER 8'h78
`define A_DTYPE 8'h7C
`define A_DATA_LO 8'hC0
`define A_DATA_HI 8'hEF
`define DT_TOUCH_THR 8'h01
`define DT_ENV_THR 8'h02
`define DT_DLY 8'h03
`define DT_IMP 8'h04
`define DT_REF 8'h05
`define DT_LOCK 8'h06
`define MODEL_AT 2'h2
`define SAMP_MAX 9'h1FF
`define SAMP_MIN 9'h000
`define RUN_BASE 3'h3
`define CAL_LAST 4'h7
`define CAL_AVG_SH 3
`define THR_SH 4
`define HYST_SH 2
`define MULT_BASE_SH 3
`define LFSR_SEED 7'h01
`define NEED_OFF 5'h01
`define NEED_M0 5'h0A
`define NEED_M1 5'h12
`define NEED_M2 5'h14
`endif

// ===== hw/cap_sense_pkg.sv
// types of the capacitive sense controller
// channel counts come from the cfg header; field widths are fixed here
`include "cap_sense_cfg.svh"
package cap_sense_pkg;
  typedef enum logic [0:0] {SC_IDLE = 1'b0, SC_MEAS = 1'b1} scan_e;
  typedef struct packed {
    logic en;
    logic [5:0] touchHyst;
    logic atBusy;
    logic [`CH_N-1:0] sel;
    logic [7:0] calInt;
    logic [7:0] calMod;
    logic [7:0] medianFilter;
    logic [7:0] dtype;
    logic [`CH_N-1:0][8:0] touchThr;
    logic [`CH_N-1:0][8:0] envThr;
    logic [`CH_N-1:0][5:0] dly;
    logic [`CH_N-1:0][12:0] imp;
    logic [`CH_N-1:0][12:0] calRef;
    logic [`CH_N-1:0][12:0] lock;
    logic [`CH_N-1:0][15:0] csum;
    logic [`CH_N-1:0] touch;
    logic [`CH_N-1:0] atPend;
    scan_e st;
    logic [4:0] ch;
    logic [6:0] baseCnt;
    logic [10:0] mclkCnt;
    logic [6:0] lfsr;
    logic [2:0] runCnt;
    logic [2:0] runLen;
    logic [4:0] nSamp;
    logic [13:0] sum;
    logic [8:0] mn;
    logic [8:0] mx;
    logic [21:0] tickCnt;
    logic [14:0] calCnt;
    logic calActive;
    logic [3:0] calIdx;
    logic [4:0] spaceCnt;
    logic drive;
    logic latch;
    logic [5:0] dlyOut;
    logic [7:0] rd;
  } cs_state_s;
endpackage

// ===== hw/cap_sense_ctrl.sv
// capacitive sense controller: scan, filter, touch compare, calibration
// byte register port from the serial host front end; analog front end
// returns a 9-bit sample, taken on the edge that raises senseLatch
`timescale 1ns/10ps
module cap_sense_ctrl
  import cap_sense_pkg::*;
#(
  parameter int TICK10 = `CAL_UNIT_CYC
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [10:0] sclkDiv,
  input wire logic [8:0] senseSample,
  output logic senseDrive,
  output logic senseLatch,
  output logic [4:0] senseChannel,
  output logic [5:0] senseDelay,
  output logic [`CH_N-1:0] touchDetect
);
  cs_state_s s_r;
  cs_state_s s_nxt;
  logic [7:0] idx;
  logic [4:0] dch;
  logic [10:0] div;
  logic [4:0] need;
  logic [13:0] sumN;
  logic [8:0] mnN;
  logic [8:0] mxN;
  logic [12:0] rdg;
  logic [8:0] thr9;
  logic [12:0] thr;
  logic [12:0] delta;
  logic [14:0] calIv;
  logic [15:0] rowv;
  logic [8:0] smp;

  // next enabled channel after cur, wrapping
  function automatic logic [4:0] nextCh(input logic [4:0] cur, input logic [`CH_N-1:0] sel);
    logic [4:0] c;
    logic [4:0] r;
    logic hit;
    c = cur;
    r = cur;
    hit = 1'b0;
    for (int i = 0; i < `CH_N; i++)
    begin
      c = (c == 5'(`CH_N - 1)) ? 5'h00 : 5'(c + 5'h01);
      if (!hit && sel[c])
      begin
        r = c;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // outputs straight from the state register
  assign regRdData = s_r.rd;
  assign senseDrive = s_r.drive;
  assign senseLatch = s_r.latch;
  assign senseChannel = s_r.ch;
  assign senseDelay = s_r.dlyOut;
  assign touchDetect = s_r.touch;

  // next-state logic
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.latch = 1'b0;
    idx = regAddr - `A_DATA_LO;
    dch = idx[5:1];
    div = (sclkDiv < `DIV_MIN) ? `DIV_MIN : ((sclkDiv > `DIV_MAX) ? `DIV_MAX : sclkDiv);
    smp = senseSample;
    sumN = s_r.sum + 14'(smp);
    mnN = (s_r.nSamp == 5'h00 || smp < s_r.mn) ? smp : s_r.mn;
    mxN = (s_r.nSamp == 5'h00 || smp > s_r.mx) ? smp : s_r.mx;
    need = `NEED_OFF;
    rdg = 13'(smp) << `THR_SH;
    // filter length and 13-bit scaling per mode
    if (s_r.medianFilter[0])
    begin
      case (s_r.medianFilter[2:1])
        2'h0:
        begin
          need = `NEED_M0;
          rdg = 13'((sumN - 14'(mnN) - 14'(mxN)) << 1);
        end
        2'h1:
        begin
          need = `NEED_M1;
          rdg = 13'(sumN - 14'(mnN) - 14'(mxN));
        end
        default:
        begin
          need = `NEED_M2;
          rdg = 13'(sumN - 14'({mnN, 1'b0}) - 14'({mxN, 1'b0}));
        end
      endcase
    end
    // hysteresis on the touch threshold
    thr9 = s_r.touchThr[s_r.ch];
    if (s_r.touch[s_r.ch])
    begin
      thr9 = (s_r.touchThr[s_r.ch] > (9'(s_r.touchHyst) << `HYST_SH)) ?
        9'(s_r.touchThr[s_r.ch] - (9'(s_r.touchHyst) << `HYST_SH)) : 9'h000;
    end
    thr = 13'(thr9) << `THR_SH;
    delta = (s_r.calRef[s_r.ch] > rdg) ? 13'(s_r.calRef[s_r.ch] - rdg) : 13'h0000;
    calIv = 15'(s_r.calInt[5:0]) << (`MULT_BASE_SH + 2 * s_r.calInt[7:6]);

    // register writes
    if (regWr)
    begin
      case (regAddr)
        `A_CTRL:
        begin
          s_nxt.en = regWrData[7];
          s_nxt.touchHyst = regWrData[6:1];
          if (regWrData[0] && regWrData[7] && !s_r.atBusy)
          begin
            s_nxt.atBusy = 1'b1;
            s_nxt.atPend = s_r.sel;
          end
        end
        `A_SEL0: s_nxt.sel[7:0] = regWrData;
        `A_SEL1: s_nxt.sel[15:8] = regWrData;
        `A_SEL2: s_nxt.sel[23:16] = regWrData;
        `A_CINT: s_nxt.calInt = regWrData;
        `A_CMOD: s_nxt.calMod = regWrData;
        `A_FILTER: s_nxt.medianFilter = regWrData;
        `A_DTYPE:
        begin
          s_nxt.dtype = regWrData;
          if (regWrData == `DT_LOCK && s_r.dtype != `DT_LOCK)
            s_nxt.lock = s_r.imp;
        end
        default:
        begin
          // threshold ports are writable; delay ports only outside the auto-tune model
          if (regAddr >= `A_DATA_LO && regAddr <= `A_DATA_HI)
          begin
            case (s_r.dtype)
              `DT_TOUCH_THR:
                if (idx[0]) s_nxt.touchThr[dch][8] = regWrData[0];
                else s_nxt.touchThr[dch][7:0] = regWrData;
              `DT_ENV_THR:
                if (idx[0]) s_nxt.envThr[dch][8] = regWrData[0];
                else s_nxt.envThr[dch][7:0] = regWrData;
              `DT_DLY:
                if (!idx[0] && s_r.calMod[2:1] != `MODEL_AT)
                  s_nxt.dly[dch] = regWrData[5:0];
              default: s_nxt.dly[dch] = s_r.dly[dch];
            endcase
          end
        end
      endcase
    end

    // register reads, one cycle latency; data ports by type
    if (regRd)
    begin
      rowv = 16'h0000;
      if (regAddr >= `A_DATA_LO && regAddr <= `A_DATA_HI)
      begin
        case (s_r.dtype)
          `DT_TOUCH_THR: rowv = 16'(s_r.touchThr[dch]);
          `DT_ENV_THR: rowv = 16'(s_r.envThr[dch]);
          `DT_DLY: rowv = 16'(s_r.dly[dch]);
          `DT_IMP: rowv = 16'(s_r.imp[dch]);
          `DT_REF: rowv = 16'(s_r.calRef[dch]);
          `DT_LOCK: rowv = 16'(s_r.lock[dch]);
          default: rowv = 16'h0000;
        endcase
      end
      case (regAddr)
        `A_CTRL: s_nxt.rd = {s_r.en, s_r.touchHyst, s_r.atBusy};
        `A_SEL0: s_nxt.rd = s_r.sel[7:0];
        `A_SEL1: s_nxt.rd = s_r.sel[15:8];
        `A_SEL2: s_nxt.rd = s_r.sel[23:16];
        `A_CINT: s_nxt.rd = s_r.calInt;
        `A_CMOD: s_nxt.rd = s_r.calMod;
        `A_FILTER: s_nxt.rd = s_r.medianFilter;
        `A_DTYPE: s_nxt.rd = s_r.dtype;
        default: s_nxt.rd = idx[0] ? rowv[15:8] : rowv[7:0];
      endcase
    end
    else
    begin
      rowv = 16'h0000;
    end

    // calibration timer and eight-sample averaging
    s_nxt.tickCnt = (s_r.tickCnt == 22'(TICK10 - 1)) ? 22'h000000 : 22'(s_r.tickCnt + 22'h1);
    if (!s_r.en || !s_r.calMod[0])
    begin
      s_nxt.calCnt = 15'h0000;
      s_nxt.calActive = 1'b0;
    end
    else if (s_r.tickCnt == 22'(TICK10 - 1))
    begin
      if (!s_r.calActive)
      begin
        s_nxt.calCnt = 15'(s_r.calCnt + 15'h1);
        if (calIv != 15'h0000 && 15'(s_r.calCnt + 15'h1) >= calIv)
        begin
          s_nxt.calActive = 1'b1;
          s_nxt.calIdx = 4'h0;
          s_nxt.spaceCnt = 5'h00;
          s_nxt.csum = '0;
        end
      end
      else if (s_r.spaceCnt >= s_r.calMod[7:3])
      begin
        s_nxt.spaceCnt = 5'h00;
        s_nxt.calIdx = 4'(s_r.calIdx + 4'h1);
        for (int c = 0; c < `CH_N; c++)
        begin
          s_nxt.csum[c] = 16'(s_r.csum[c] + 16'(s_r.imp[c]));
          if (s_r.calIdx == `CAL_LAST && !s_r.touch[c])
            s_nxt.calRef[c] = 13'(s_nxt.csum[c] >> `CAL_AVG_SH);
        end
        if (s_r.calIdx == `CAL_LAST)
        begin
          s_nxt.calActive = 1'b0;
          s_nxt.calCnt = 15'h0000;
        end
      end
      else
      begin
        s_nxt.spaceCnt = 5'(s_r.spaceCnt + 5'h01);
      end
    end

    // channel scan and sampling
    if (!s_r.en || s_r.sel == '0)
    begin
      s_nxt.st = SC_IDLE;
      s_nxt.drive = 1'b0;
    end
    else
    begin
      case (s_r.st)
        SC_IDLE:
        begin
          s_nxt.st = SC_MEAS;
          s_nxt.ch = s_r.sel[s_r.ch] ? s_r.ch : nextCh(s_r.ch, s_r.sel);
          s_nxt.nSamp = 5'h00;
          s_nxt.sum = 14'h0000;
          s_nxt.runCnt = 3'h0;
          s_nxt.runLen = `RUN_BASE;
          s_nxt.baseCnt = 7'h00;
          s_nxt.mclkCnt = 11'h000;
        end
        SC_MEAS:
        begin
          s_nxt.baseCnt = (s_r.baseCnt == 7'(`BASE_DIV - 1)) ? 7'h00 : 7'(s_r.baseCnt + 7'h01);
          if (s_r.baseCnt == 7'(`BASE_DIV - 1))
          begin
            s_nxt.mclkCnt = (s_r.mclkCnt >= 11'(div - 11'h1)) ? 11'h000 : 11'(s_r.mclkCnt + 11'h1);
            if (s_r.mclkCnt >= 11'(div - 11'h1))
            begin
              // x^7 + x^6 + 1 maximal sequence drives the electrode
              s_nxt.lfsr = {s_r.lfsr[5:0], s_r.lfsr[6] ^ s_r.lfsr[5]};
              s_nxt.drive = s_r.lfsr[0];
              s_nxt.runCnt = 3'(s_r.runCnt + 3'h1);
              if (3'(s_r.runCnt + 3'h1) >= s_r.runLen)
              begin
                // sample lengths 3..6 uniform: mean 4.5 clocks
                s_nxt.runCnt = 3'h0;
                s_nxt.runLen = 3'(`RUN_BASE + 3'(s_r.lfsr[1:0]));
                s_nxt.latch = 1'b1;
                if ((smp == `SAMP_MAX || smp == `SAMP_MIN) &&
                    (s_r.calMod[2:1] == `MODEL_AT || s_r.atBusy))
                begin
                  // out of window: step the delay, restart the reading
                  if (smp == `SAMP_MAX && s_r.dly[s_r.ch] != 6'h3F)
                    s_nxt.dly[s_r.ch] = 6'(s_r.dly[s_r.ch] + 6'h01);
                  else if (smp == `SAMP_MIN && s_r.dly[s_r.ch] != 6'h00)
                    s_nxt.dly[s_r.ch] = 6'(s_r.dly[s_r.ch] - 6'h01);
                  s_nxt.nSamp = 5'h00;
                  s_nxt.sum = 14'h0000;
                end
                else if (5'(s_r.nSamp + 5'h01) >= need)
                begin
                  s_nxt.imp[s_r.ch] = rdg;
                  s_nxt.touch[s_r.ch] = (delta > thr);
                  if (s_r.atPend[s_r.ch])
                  begin
                    s_nxt.calRef[s_r.ch] = rdg;
                    s_nxt.touch[s_r.ch] = 1'b0;
                    s_nxt.atPend[s_r.ch] = 1'b0;
                  end
                  s_nxt.ch = nextCh(s_r.ch, s_r.sel);
                  s_nxt.nSamp = 5'h00;
                  s_nxt.sum = 14'h0000;
                end
                else
                begin
                  s_nxt.nSamp = 5'(s_r.nSamp + 5'h01);
                  s_nxt.sum = sumN;
                  s_nxt.mn = mnN;
                  s_nxt.mx = mxN;
                end
              end
            end
          end
        end
        default: s_nxt.st = SC_IDLE;
      endcase
    end
    // tune finishes once every selected channel was re-centred
    if (s_r.atBusy && (s_r.atPend == '0 || !s_r.en))
    begin
      s_nxt.atBusy = 1'b0;
      s_nxt.atPend = '0;
    end
    s_nxt.dlyOut = s_nxt.dly[s_nxt.ch];
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.lfsr <= `LFSR_SEED;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_latchGap;
    s_r.latch |=> !s_r.latch [*8];
  endproperty
  a_latchGap: assert property (p_latchGap) else $error("samples too close");
  property p_disabled;
    !s_r.en |=> (s_r.st == SC_IDLE) && !s_r.drive;
  endproperty
  a_disabled: assert property (p_disabled) else $error("scan runs while disabled");
  property p_selOnly;
    s_r.latch && $stable(s_r.sel) |-> s_r.sel[$past(s_r.ch)];
  endproperty
  a_selOnly: assert property (p_selOnly) else $error("deselected channel sampled");
  property p_lockHold;
    (s_r.dtype == `DT_LOCK) && ($past(s_r.dtype) == `DT_LOCK) |-> $stable(s_r.lock);
  endproperty
  a_lockHold: assert property (p_lockHold) else $error("snapshot changed");
  property p_lockTake;
    regWr && regAddr == `A_DTYPE && regWrData == `DT_LOCK && s_r.dtype != `DT_LOCK
      |=> s_r.lock == $past(s_r.imp);
  endproperty
  a_lockTake: assert property (p_lockTake) else $error("snapshot not taken");
  property p_atStart;
    regWr && regAddr == `A_CTRL && regWrData[7] && regWrData[0] && !s_r.atBusy && s_r.sel != '0
      |=> s_r.atBusy;
  endproperty
  a_atStart: assert property (p_atStart) else $error("tune did not start");
  property p_atIgnore;
    s_r.atBusy |=> (s_r.atPend & ~$past(s_r.atPend)) == '0;
  endproperty
  a_atIgnore: assert property (p_atIgnore) else $error("tune restarted while busy");
  property p_readThr;
    regRd && regAddr == `A_DATA_LO && s_r.dtype == `DT_TOUCH_THR
      |=> s_r.rd == $past(s_r.touchThr[0][7:0]);
  endproperty
  a_readThr: assert property (p_readThr) else $error("wrong port data");
  property p_calOff;
    !s_r.calMod[0] |=> !s_r.calActive;
  endproperty
  a_calOff: assert property (p_calOff) else $error("calibration while disabled");
  property p_atNoTouch;
    s_r.en && s_r.atPend[s_r.ch] && !s_nxt.atPend[s_r.ch] |=> !s_r.touch[$past(s_r.ch)];
  endproperty
  a_atNoTouch: assert property (p_atNoTouch) else $error("touch left after tune");
  c_atDone: cover property (s_r.atBusy ##1 !s_r.atBusy);
  c_lock: cover property (regWr && regAddr == `A_DTYPE && regWrData == `DT_LOCK);
  c_calDone: cover property (s_r.calActive ##1 !s_r.calActive);
  c_touch: cover property (s_r.touch != '0);
endmodule

// ===== testbench/sense_front_model.sv
// analog front end stand-in: one 9-bit sample for the channel being measured
// assumes the controller takes senseSample on the edge that raises senseLatch
`timescale 1ns/10ps
`include "cap_sense_cfg.svh"
module sense_front_model
  import cap_sense_pkg::*;
(
  input wire logic [4:0] senseChannel,
  input wire logic [5:0] senseDelay,
  input wire logic [`CH_N-1:0] fingerMask,
  input wire logic [`CH_N-1:0] railMask,
  output logic [8:0] senseSample
);
  // railed electrode at zero delay, a finger lowers the reading
  always_comb
  begin
    if (railMask[senseChannel] && senseDelay == 6'h00)
      senseSample = 9'h1FF;
    else if (fingerMask[senseChannel])
      senseSample = 9'h0C0;
    else
      senseSample = 9'h100;
  end
endmodule

// ===== testbench/tb.sv
// self-checking bench of the capacitive sense controller
// assumes the front end stand-in and the design files are compiled first
`timescale 1ns/10ps
`include "cap_sense_cfg.svh"
module tb;
  import cap_sense_pkg::*;
  logic clk_sys;
  logic rst;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  logic [8:0] senseSample;
  logic senseDrive;
  logic senseLatch;
  logic [4:0] senseChannel;
  logic [5:0] senseDelay;
  logic [`CH_N-1:0] touchDetect;
  logic [`CH_N-1:0] fingerMask;
  logic [`CH_N-1:0] railMask;
  logic [10:0] sclkDiv;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int gap = 0;
  logic gapValid = 1'b0;

  // divider driven below its legal range: the design must clamp it up to 32
  cap_sense_ctrl #(.TICK10(100)) dut_u (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .sclkDiv(sclkDiv), .senseSample(senseSample), .senseDrive(senseDrive),
    .senseLatch(senseLatch), .senseChannel(senseChannel), .senseDelay(senseDelay),
    .touchDetect(touchDetect));
  sense_front_model front_u (.senseChannel(senseChannel), .senseDelay(senseDelay),
    .fingerMask(fingerMask), .railMask(railMask), .senseSample(senseSample));

  // 250 MHz core clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // hang guard, scan watch and sample spacing: only channel 0 is selected while the scan is enabled
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    gap <= gap + 1;
    if (regWr && regAddr == 8'h70)
      gapValid <= 1'b0;
    if (!rst && senseLatch === 1'b1)
    begin
      gap <= 1;
      gapValid <= 1'b1;
      if (senseChannel !== 5'h00)
      begin
        fails = fails + 1;
        $display("BAD senseChannel expected %h seen %h", 5'h00, senseChannel);
      end
      if (gapValid)
      begin
        comparisons = comparisons + 1;
        // 125 cycles a base tick, divider 32, 3 to 6 measurement clocks a sample
        if (gap % 4000 != 0 || gap < 12000 || gap > 24000)
        begin
          fails = fails + 1;
          $display("BAD sample spacing expected 12000..24000 step 4000 seen %0d", gap);
        end
      end
    end
    if (cycles == 95000)
    begin
      fails = fails + 1;
      $display("BAD cycles expected below %0d seen %0d", 95000, cycles);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one byte write, strobe lowered and one edge let pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(posedge clk_sys);
    #1;
    regWr = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // one byte read, data registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    regRd = 1'b1;
    @(posedge clk_sys);
    #1;
    regRd = 1'b0;
    d = regRdData;
    @(posedge clk_sys);
    #1;
  endtask

  // channel port: low byte at even address, high byte next
  task automatic wr16(input logic [4:0] ch, input logic [15:0] v);
    wr({2'h3, ch, 1'b0}, v[7:0]);
    wr({2'h3, ch, 1'b1}, v[15:8]);
  endtask

  task automatic rd16(input logic [4:0] ch, output logic [15:0] v);
    logic [7:0] lo;
    logic [7:0] hi;
    rd({2'h3, ch, 1'b0}, lo);
    rd({2'h3, ch, 1'b1}, hi);
    v = {hi, lo};
  endtask

  task automatic test_reset();
    logic [7:0] b;
    logic [7:0] adr [10] = '{8'h70, 8'h72, 8'h73, 8'h74, 8'h76, 8'h77, 8'h78, 8'h7C,
      8'h71, 8'h7F};
    foreach (adr[i])
    begin
      rd(adr[i], b);
      chk("reset value", 16'h0000, {8'h00, b});
    end
    chk("idle outputs", 16'h0000, {14'h0000, senseDrive, senseLatch});
    chk("idle touch", 16'h0000, touchDetect[15:0]);
    $display("test reset done");
  endtask

  task automatic test_regs();
    logic [7:0] b;
    logic [7:0] adr [7] = '{8'h72, 8'h73, 8'h74, 8'h76, 8'h77, 8'h78, 8'h7C};
    foreach (adr[i])
    begin
      wr(adr[i], 8'h3C + 8'(i));
      rd(adr[i], b);
      chk("read back", {8'h00, 8'h3C + 8'(i)}, {8'h00, b});
      wr(adr[i], 8'h00);
    end
    wr(8'h71, 8'hFF);
    rd(8'h71, b);
    chk("unmapped", 16'h0000, {8'h00, b});
    $display("test regs done");
  endtask

  task automatic test_ports();
    logic [15:0] v;
    wr(8'h7C, 8'h01);
    wr16(5'd0, 16'h0010);
    wr16(5'd1, 16'hFF34);
    rd16(5'd0, v);
    chk("touch threshold 0", 16'h0010, v);
    rd16(5'd1, v);
    chk("touch threshold 1", 16'h0134, v);
    wr(8'h7C, 8'h02);
    wr16(5'd23, 16'h01FF);
    rd16(5'd23, v);
    chk("environment threshold 23", 16'h01FF, v);
    wr(8'h7C, 8'h03);
    wr16(5'd5, 16'h002A);
    rd16(5'd5, v);
    chk("delay 5", 16'h002A, v);
    wr(8'h77, 8'h04);
    wr16(5'd5, 16'h0015);
    rd16(5'd5, v);
    chk("delay 5 locked", 16'h002A, v);
    $display("test ports done");
  endtask

  task automatic test_tune();
    logic [7:0] b;
    logic [15:0] v;
    int n;
    // all configuration first, auto-tune model, then enable with the tune command
    wr(8'h72, 8'h01);
    wr(8'h78, 8'h00);
    wr(8'h77, 8'h04);
    wr(8'h70, 8'h8B);
    rd(8'h70, b);
    chk("control busy", 16'h008B, {8'h00, b});
    wr(8'h70, 8'h8B);
    for (n = 0; n < 30000 && b[0] !== 1'b0; n++)
      rd(8'h70, b);
    chk("control done", 16'h008A, {8'h00, b});
    chk("retuned delay", 16'h0001, {10'h000, senseDelay});
    wr(8'h7C, 8'h04);
    rd16(5'd0, v);
    chk("impedance", 16'h1000, v);
    wr(8'h7C, 8'h05);
    rd16(5'd0, v);
    chk("reference", 16'h1000, v);
    chk("no touch", 16'h0000, touchDetect[15:0]);
    $display("test tune done");
  endtask

  task automatic test_lock();
    logic [15:0] v;
    int n;
    wr(8'h7C, 8'h06);
    rd16(5'd0, v);
    chk("snapshot", 16'h1000, v);
    fingerMask = 24'h000001;
    for (n = 0; n < 30000 && touchDetect[0] !== 1'b1; n++)
    begin
      @(posedge clk_sys);
      #1;
    end
    chk("touch", 16'h0001, touchDetect[15:0]);
    rd16(5'd0, v);
    chk("snapshot held", 16'h1000, v);
    wr(8'h7C, 8'h04);
    rd16(5'd0, v);
    chk("live impedance", 16'h0C00, v);
    wr(8'h7C, 8'h05);
    rd16(5'd0, v);
    chk("live reference", 16'h1000, v);
    wr(8'h7C, 8'h00);
    wr(8'h7C, 8'h06);
    rd16(5'd0, v);
    chk("snapshot refreshed", 16'h0C00, v);
    $display("test lock done");
  endtask

  task automatic test_cal();
    logic [15:0] v;
    int n;
    // stop, widen the threshold, switch calibration on, restart
    wr(8'h70, 8'h00);
    wr(8'h7C, 8'h01);
    wr16(5'd0, 16'h0050);
    wr(8'h76, 8'h01);
    wr(8'h77, 8'h05);
    wr(8'h7C, 8'h05);
    wr(8'h70, 8'h80);
    v = 16'h1000;
    for (n = 0; n < 5000 && v !== 16'h0C00; n++)
      rd16(5'd0, v);
    chk("calibrated reference", 16'h0C00, v);
    chk("no touch under wide threshold", 16'h0000, touchDetect[15:0]);
    $display("test cal done");
  endtask

  // main sequence
  initial
  begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    fingerMask = '0;
    railMask = 24'h000001;
    sclkDiv = 11'h001;
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    test_reset();
    test_regs();
    test_ports();
    test_tune();
    test_lock();
    test_cal();
    give_verdict();
  end
endmodule
